// ===== hw/clock_pkg.sv
package clock_pkg;

   // ****************************************************************
   // Register map (APB byte addresses)
   // ****************************************************************
   localparam logic [7:0] DIV_CTRL_OFFSET = 8'h00;
   localparam logic [7:0] FUSE_OFFSET     = 8'h04;
   localparam logic [7:0] STATUS_OFFSET   = 8'h08;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int DIV_EN_BIT     = 7;
   localparam int FUSE_SUT_LSB   = 4;
   localparam int FUSE_AMPLIFIER_OPTION_FUSE_BIT = 6;
   localparam int STAT_KIND_LSB  = 1;
   localparam int STAT_RSVD_BIT  = 3;
   localparam int STAT_ACTEN_BIT = 4;
   localparam int STAT_FACT_LSB  = 8;

   // ****************************************************************
   // Values after reset
   // ****************************************************************
   localparam logic [7:0] DIV_CTRL_RESET = 8'h00;
   localparam logic [3:0] CLOCK_SOURCE_FUSES_RESET    = 4'h1;
   localparam logic [1:0] SUT_RESET      = 2'h2;
   localparam logic       AMPLIFIER_OPTION_FUSE_RESET    = 1'h1;

   // ****************************************************************
   // Divider
   // ****************************************************************
   localparam logic [7:0] DIV_BASE      = 8'h81;
   localparam logic [7:0] UNDIV_FACTOR  = 8'h01;

   // ****************************************************************
   // Clock source codes
   // ****************************************************************
   localparam logic [3:0] XTAL_LOW_CODE = 4'ha;
   localparam logic [3:0] LF_XTAL_CODE  = 4'h9;
   localparam logic [3:0] RC_LOW_CODE   = 4'h5;
   localparam logic [3:0] RC_HIGH_CODE  = 4'h8;

   localparam logic [1:0] KIND_XTAL  = 2'h0;
   localparam logic [1:0] KIND_LF    = 2'h1;
   localparam logic [1:0] KIND_RC    = 2'h2;
   localparam logic [1:0] KIND_OTHER = 2'h3;

   // ****************************************************************
   // Start-up counts in source clock cycles
   // ****************************************************************
   localparam logic [16:0] CYCLES_258 = 17'h00102;
   localparam logic [16:0] CYCLES_1K  = 17'h00400;
   localparam logic [16:0] CYCLES_18  = 17'h00012;
   localparam logic [16:0] CYCLES_6   = 17'h00006;

   // Reset delay, in watchdog oscillator cycles
   localparam logic [16:0] WDT_SHORT_CYCLES = 17'h01000;

   localparam logic [1:0] DELAY_NONE  = 2'h0;
   localparam logic [1:0] DELAY_SHORT = 2'h1;
   localparam logic [1:0] DELAY_LONG  = 2'h2;

   typedef enum logic [4:0] {
      PH_OSC   = 5'h01,
      PH_DELAY = 5'h02,
      PH_RUN   = 5'h04,
      PH_SLEEP = 5'h08,
      PH_WAKE  = 5'h10
   } phase_type;

endpackage

// ===== hw/clock_divider.sv
`timescale 1ns/10ps
module clock_divider
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       enable,
   input  wire logic [7:0] factor,
   output logic            tick,
   output logic            div_clk,
   output logic            active_enable,
   output logic [7:0]      active_factor
);

   typedef struct packed {
      logic [7:0] cnt;
      logic       en;
      logic [7:0] n;
      logic       clk;
   } div_state_type;

   div_state_type s_q;
   div_state_type s_d;
   logic          boundary;

   // ****************************************************************
   // Factor and enable are only taken at a period boundary, so no
   // phase of the divided clock is ever cut short
   // ****************************************************************
   always_comb
   begin
      s_d      = s_q;
      boundary = !s_q.en || (s_q.cnt == s_q.n - 8'h01);
      if (boundary)
      begin
         s_d.en  = enable;
         s_d.n   = factor;
         s_d.cnt = 8'h00;
      end
      else
      begin
         s_d.cnt = s_q.cnt + 8'h01;
      end
      // High for the first half, so both phases last at least one cycle
      s_d.clk = s_d.en && (s_d.cnt < {1'b0, s_d.n[7:1]});
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_q <= '{cnt: 8'h00, en: 1'b0, n: clock_pkg::DIV_BASE, clk: 1'b0};
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign tick          = !s_q.en || (s_q.cnt == 8'h00);
   assign div_clk       = s_q.clk;
   assign active_enable = s_q.en;
   assign active_factor = s_q.en ? s_q.n : clock_pkg::UNDIV_FACTOR;

endmodule // clock_divider

// ===== hw/clock_source_startup_and_divider.sv
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/10ps
// Contract
// - Enabled divider runs CPU, I/O, ADC, flash clocks at source over (129 - select).
// - Division factors from 2 to 129 via the seven-bit select field.
// - Select field changes only while divide enable is zero.
// - Write setting enable adopts the select value of that same write.
// - Write clearing enable discards its select value and runs undivided.
// - Divide enable may be written at any time while running.
// - Fuses leave reset as source 0001 and start-up 10.
// - Crystal range picked by select bits 3..1; programmed amplifier fuse gives full swing.
// - Crystal, bit0 zero: start-up 00/01 give 258 cycles plus short/long delay.
// - Crystal 0/10, 0/11, 1/00 give 1K cycles with none/short/long delay.
// - Crystal, bit0 one: start-up 01/10/11 give 16K cycles, none/short/long.
// - Source code 1001 selects the low-frequency watch crystal.
// - Watch crystal: 00/01 give 1K plus short/long; 10 gives 32K plus long.
// - Source codes 0101 to 1000 select the external RC oscillator.
// - RC: 00/01/10 give 18 cycles none/short/long; 11 gives 6 plus short.
// - Wake from power-down or power-save counts start-up cycles before running.
// - Reset delay counted on watchdog oscillator: 4096 or 65536 cycles.
module clock_source_startup_and_divider
#(
   parameter logic [16:0] STARTUP_16K_CYCLES = 17'h04000,
   parameter logic [16:0] STARTUP_32K_CYCLES = 17'h08000,
   parameter logic [16:0] WDT_LONG_CYCLES    = 17'h10000
)
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        wdt_osc_clk,
   input  wire logic        sleep_enter,
   input  wire logic        wake_event,
   output logic             cpu_run,
   output logic             sys_clk_en,
   output logic             sys_clk_div,
   output logic [1:0]       osc_kind,
   output logic [2:0]       osc_range,
   output logic             osc_full_swing,
   output logic             internal_cap_enable
);

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic                 div_en;
      logic [6:0]           div_sel;
      logic [3:0]           clock_source_fuses;
      logic [1:0]           startup_fuses;
      logic                 amplifier_option_fuse;
      clock_pkg::phase_type phase;
      logic [16:0]          osc_cnt;
      logic [16:0]          wdt_cnt;
      logic [1:0]           wdt_sync;
      logic                 wdt_prev;
      logic [31:0]          rdata;
      logic                 run;
   } top_state_type;

   top_state_type s_q;
   top_state_type s_d;

   logic        setup_cyc;
   logic        access_cyc;
   logic        hit_ctrl;
   logic        hit_fuse;
   logic        hit_stat;
   logic        wdt_edge;
   logic [1:0]  kind;
   logic        reserved_sut;
   logic [16:0] su_cycles;
   logic [1:0]  su_delay;
   logic [16:0] delay_cycles;
   logic        div_tick;
   logic        div_clk;
   logic        act_en;
   logic [7:0]  act_factor;
   logic [7:0]  factor_req;

   // ****************************************************************
   // Source decode
   // ****************************************************************
   always_comb
   begin
      reserved_sut = 1'b0;
      if (s_q.clock_source_fuses >= clock_pkg::XTAL_LOW_CODE)
      begin
         kind = clock_pkg::KIND_XTAL;
      end
      else if (s_q.clock_source_fuses == clock_pkg::LF_XTAL_CODE)
      begin
         kind = clock_pkg::KIND_LF;
      end
      else if (s_q.clock_source_fuses >= clock_pkg::RC_LOW_CODE)
      begin
         kind = clock_pkg::KIND_RC;
      end
      else
      begin
         kind = clock_pkg::KIND_OTHER;
      end
      su_cycles = clock_pkg::CYCLES_6;
      su_delay  = clock_pkg::DELAY_NONE;
      case (kind)
         clock_pkg::KIND_XTAL:
         begin
            case ({s_q.clock_source_fuses[0], s_q.startup_fuses})
               3'h0:
               begin
                  su_cycles = clock_pkg::CYCLES_258;
                  su_delay  = clock_pkg::DELAY_SHORT;
               end
               3'h1:
               begin
                  su_cycles = clock_pkg::CYCLES_258;
                  su_delay  = clock_pkg::DELAY_LONG;
               end
               3'h2:
               begin
                  su_cycles = clock_pkg::CYCLES_1K;
                  su_delay  = clock_pkg::DELAY_NONE;
               end
               3'h3:
               begin
                  su_cycles = clock_pkg::CYCLES_1K;
                  su_delay  = clock_pkg::DELAY_SHORT;
               end
               3'h4:
               begin
                  su_cycles = clock_pkg::CYCLES_1K;
                  su_delay  = clock_pkg::DELAY_LONG;
               end
               3'h5:
               begin
                  su_cycles = STARTUP_16K_CYCLES;
                  su_delay  = clock_pkg::DELAY_NONE;
               end
               3'h6:
               begin
                  su_cycles = STARTUP_16K_CYCLES;
                  su_delay  = clock_pkg::DELAY_SHORT;
               end
               default:
               begin
                  su_cycles = STARTUP_16K_CYCLES;
                  su_delay  = clock_pkg::DELAY_LONG;
               end
            endcase
         end
         clock_pkg::KIND_LF:
         begin
            case (s_q.startup_fuses)
               2'h0:
               begin
                  su_cycles = clock_pkg::CYCLES_1K;
                  su_delay  = clock_pkg::DELAY_SHORT;
               end
               2'h1:
               begin
                  su_cycles = clock_pkg::CYCLES_1K;
                  su_delay  = clock_pkg::DELAY_LONG;
               end
               default:
               begin
                  // Reserved code falls back to the safest, slowest start
                  reserved_sut = (s_q.startup_fuses == 2'h3);
                  su_cycles    = STARTUP_32K_CYCLES;
                  su_delay     = clock_pkg::DELAY_LONG;
               end
            endcase
         end
         clock_pkg::KIND_RC:
         begin
            su_cycles = (s_q.startup_fuses == 2'h3) ? clock_pkg::CYCLES_6 : clock_pkg::CYCLES_18;
            su_delay  = (s_q.startup_fuses == 2'h3) ? clock_pkg::DELAY_SHORT : s_q.startup_fuses;
         end
         default:
         begin
            // Internal sources are out of scope here: fixed 6-cycle start, delay set by the start-up fuses (11 gives long)
            reserved_sut = (s_q.startup_fuses == 2'h3);
            su_delay     = reserved_sut ? clock_pkg::DELAY_LONG : s_q.startup_fuses;
         end
      endcase
      if (su_delay == clock_pkg::DELAY_LONG)
      begin
         delay_cycles = WDT_LONG_CYCLES;
      end
      else
      begin
         delay_cycles = clock_pkg::WDT_SHORT_CYCLES;
      end
   end

   // ****************************************************************
   // APB decode
   // ****************************************************************
   always_comb
   begin
      setup_cyc  = psel && !penable;
      access_cyc = psel && penable;
      hit_ctrl   = 1'b0;
      hit_fuse   = 1'b0;
      hit_stat   = 1'b0;
      if (paddr == clock_pkg::DIV_CTRL_OFFSET)
      begin
         hit_ctrl = 1'b1;
      end
      else if (paddr == clock_pkg::FUSE_OFFSET)
      begin
         hit_fuse = 1'b1;
      end
      else if (paddr == clock_pkg::STATUS_OFFSET)
      begin
         hit_stat = 1'b1;
      end
   end

   assign wdt_edge   = s_q.wdt_sync[1] && !s_q.wdt_prev;
   assign factor_req = clock_pkg::DIV_BASE - {1'b0, s_q.div_sel};

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb
   begin
      s_d          = s_q;
      s_d.wdt_sync = {s_q.wdt_sync[0], wdt_osc_clk};
      s_d.wdt_prev = s_q.wdt_sync[1];

      if (setup_cyc)
      begin
         s_d.rdata = 32'h00000000;
         if (hit_ctrl)
         begin
            s_d.rdata[7:0] = {s_q.div_en, s_q.div_sel};
         end
         else if (hit_fuse)
         begin
            s_d.rdata[6:0] = {s_q.amplifier_option_fuse, s_q.startup_fuses, s_q.clock_source_fuses};
         end
         else if (hit_stat)
         begin
            s_d.rdata[0]                              = s_q.run;
            s_d.rdata[clock_pkg::STAT_KIND_LSB +: 2]  = kind;
            s_d.rdata[clock_pkg::STAT_RSVD_BIT]       = reserved_sut;
            s_d.rdata[clock_pkg::STAT_ACTEN_BIT]      = act_en;
            s_d.rdata[clock_pkg::STAT_FACT_LSB +: 8]  = act_factor;
         end
      end

      if (access_cyc && pwrite && hit_ctrl)
      begin
         if (pwdata[clock_pkg::DIV_EN_BIT] && !s_q.div_en)
         begin
            s_d.div_sel = pwdata[6:0];
         end
         // A clearing write keeps the old select value
         s_d.div_en = pwdata[clock_pkg::DIV_EN_BIT];
      end
      if (access_cyc && pwrite && hit_fuse)
      begin
         // New fuse values reach the source decode and oscillator outputs on the next cycle
         s_d.clock_source_fuses = pwdata[3:0];
         s_d.startup_fuses   = pwdata[clock_pkg::FUSE_SUT_LSB +: 2];
         s_d.amplifier_option_fuse = pwdata[clock_pkg::FUSE_AMPLIFIER_OPTION_FUSE_BIT];
      end

      case (s_q.phase)
         clock_pkg::PH_OSC:
         begin
            s_d.osc_cnt = s_q.osc_cnt + 17'h00001;
            if (s_q.osc_cnt >= su_cycles - 17'h00001)
            begin
               s_d.wdt_cnt = 17'h00000;
               s_d.phase   = (su_delay == clock_pkg::DELAY_NONE) ?
                             clock_pkg::PH_RUN : clock_pkg::PH_DELAY;
               s_d.run     = (su_delay == clock_pkg::DELAY_NONE);
            end
         end
         clock_pkg::PH_DELAY:
         begin
            if (wdt_edge)
            begin
               s_d.wdt_cnt = s_q.wdt_cnt + 17'h00001;
               if (s_q.wdt_cnt >= delay_cycles - 17'h00001)
               begin
                  s_d.phase = clock_pkg::PH_RUN;
                  s_d.run   = 1'b1;
               end
            end
         end
         clock_pkg::PH_RUN:
         begin
            if (sleep_enter)
            begin
               s_d.phase = clock_pkg::PH_SLEEP;
               s_d.run   = 1'b0;
            end
         end
         clock_pkg::PH_SLEEP:
         begin
            if (wake_event)
            begin
               s_d.osc_cnt = 17'h00000;
               s_d.phase   = clock_pkg::PH_WAKE;
            end
         end
         clock_pkg::PH_WAKE:
         begin
            s_d.osc_cnt = s_q.osc_cnt + 17'h00001;
            if (s_q.osc_cnt >= su_cycles - 17'h00001)
            begin
               s_d.phase = clock_pkg::PH_RUN;
               s_d.run   = 1'b1;
            end
         end
         default:
         begin
            s_d.phase = clock_pkg::PH_OSC;
            s_d.run   = 1'b0;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_q.div_en   <= clock_pkg::DIV_CTRL_RESET[7];
         s_q.div_sel  <= clock_pkg::DIV_CTRL_RESET[6:0];
         s_q.clock_source_fuses    <= clock_pkg::CLOCK_SOURCE_FUSES_RESET;
         s_q.startup_fuses      <= clock_pkg::SUT_RESET;
         s_q.amplifier_option_fuse    <= clock_pkg::AMPLIFIER_OPTION_FUSE_RESET;
         s_q.phase    <= clock_pkg::PH_OSC;
         s_q.osc_cnt  <= 17'h00000;
         s_q.wdt_cnt  <= 17'h00000;
         s_q.wdt_sync <= 2'h0;
         s_q.wdt_prev <= 1'b0;
         s_q.rdata    <= 32'h00000000;
         s_q.run      <= 1'b0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // ****************************************************************
   // Divider
   // ****************************************************************
   clock_divider u_divider
   (
      .pclk          (pclk),
      .presetn       (presetn),
      .enable        (s_q.div_en),
      .factor        (factor_req),
      .tick          (div_tick),
      .div_clk       (div_clk),
      .active_enable (act_en),
      .active_factor (act_factor)
   );

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign prdata              = s_q.rdata;
   assign pready              = access_cyc;
   assign pslverr             = access_cyc && !(hit_ctrl || hit_fuse || hit_stat);
   assign cpu_run             = s_q.run;
   assign sys_clk_en          = s_q.run && div_tick;
   assign sys_clk_div         = div_clk;
   assign osc_kind            = kind;
   assign osc_range           = s_q.clock_source_fuses[3:1];
   assign osc_full_swing      = !s_q.amplifier_option_fuse;
   assign internal_cap_enable = !s_q.amplifier_option_fuse && (kind != clock_pkg::KIND_XTAL);

endmodule // clock_source_startup_and_divider

// ===== verif/clock_startup_properties.sv
`timescale 1ns/10ps
// ****************************************************************
// Port-level checks
// ****************************************************************
module clock_startup_properties
(
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic       pready,
   input wire logic       sleep_enter,
   input wire logic       wake_event,
   input wire logic       cpu_run,
   input wire logic       sys_clk_en,
   input wire logic       sys_clk_div,
   input wire logic [1:0] osc_kind,
   input wire logic       osc_full_swing,
   input wire logic       internal_cap_enable
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_pready_zero: assert property (psel && !penable ##1 psel && penable |-> pready)
      else $error("pready low in access cycle");
   a_undiv_restore: assert property (psel && penable && pwrite
      && paddr == clock_pkg::DIV_CTRL_OFFSET && !pwdata[clock_pkg::DIV_EN_BIT]
      |-> ##[1:140] (sys_clk_en || !cpu_run)[*4])
      else $error("clock not undivided after disable");
   a_en_needs_run: assert property (sys_clk_en |-> cpu_run)
      else $error("clock enable while halted");
   a_sleep_stop: assert property ($fell(cpu_run) |-> $past(sleep_enter))
      else $error("run dropped without sleep request");
   a_wake_min: assert property (wake_event && !cpu_run |=> !cpu_run[*5])
      else $error("wake shorter than six cycles");
   a_div_gap: assert property (sys_clk_div && sys_clk_en |=> !sys_clk_en)
      else $error("divided clock enable twice in a row");
   a_cap_option: assert property (internal_cap_enable
      |-> osc_full_swing && osc_kind != clock_pkg::KIND_XTAL)
      else $error("internal capacitor with wrong source");
   a_reset_hold: assert property ($rose(presetn) |-> !cpu_run[*6])
      else $error("run too soon after reset");
endmodule // clock_startup_properties

bind clock_source_startup_and_divider clock_startup_properties clock_startup_properties_inst
(
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .sleep_enter(sleep_enter),
   .wake_event(wake_event), .cpu_run(cpu_run), .sys_clk_en(sys_clk_en),
   .sys_clk_div(sys_clk_div), .osc_kind(osc_kind), .osc_full_swing(osc_full_swing),
   .internal_cap_enable(internal_cap_enable)
);

// ===== verif/oscillator_model.sv
`timescale 1ns/10ps
// Free-running timing oscillator; period not a multiple of pclk so
// the synchroniser sees every phase
module oscillator_model
#(
   // Period stays above four pclk periods, like a slow asynchronous timer clock
   parameter realtime HALF = 21.0
)
(
   output logic wdt_osc_clk
);
   initial
   begin
      wdt_osc_clk = 1'b0;
      forever #(HALF) wdt_osc_clk = ~wdt_osc_clk;
   end
endmodule // oscillator_model

// ===== verif/clock_source_startup_and_divider_test.sv
`timescale 1ns/10ps
module clock_source_startup_and_divider_test;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        wdt_osc_clk;
   logic        sleep_enter;
   logic        wake_event;
   logic        cpu_run;
   logic        sys_clk_en;
   logic        sys_clk_div;
   logic [1:0]  osc_kind;
   logic [2:0]  osc_range;
   logic        osc_full_swing;
   logic        internal_cap_enable;
   int          failures;
   int          n_compared;

   initial
   begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   // Shortened 16K, 32K and long-delay counts keep the run brief
   clock_source_startup_and_divider #(.STARTUP_16K_CYCLES(17'h00028),
      .STARTUP_32K_CYCLES(17'h0003c), .WDT_LONG_CYCLES(17'h00014))
   clock_source_startup_and_divider_inst
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .wdt_osc_clk(wdt_osc_clk), .sleep_enter(sleep_enter),
      .wake_event(wake_event), .cpu_run(cpu_run), .sys_clk_en(sys_clk_en),
      .sys_clk_div(sys_clk_div), .osc_kind(osc_kind), .osc_range(osc_range),
      .osc_full_swing(osc_full_swing), .internal_cap_enable(internal_cap_enable)
   );

   oscillator_model oscillator_model_inst (.wdt_osc_clk(wdt_osc_clk));

   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         failures++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic conclude;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the watchdog ends a wait for the slave's answer
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wait_run(output int n);
      n = 0;
      while (cpu_run !== 1'b1 && n < 3000)
      begin
         @(posedge pclk);
         n++;
      end
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_startup;
      logic [31:0] r;
      logic        e;
      int          n;
      wait_run(n);
      check({31'h0, n >= 150 && n <= 215}, 32'h1);
      apb(1'b0, clock_pkg::FUSE_OFFSET, 32'h0, r, e);
      check(r, 32'h00000061);
      apb(1'b0, clock_pkg::STATUS_OFFSET, 32'h0, r, e);
      check(r, 32'h00000107);
      apb(1'b1, 8'h0c, 32'h5, r, e);
      check({31'h0, e}, 32'h1);
      apb(1'b0, 8'h0c, 32'h0, r, e);
      check({r[30:0], e}, 32'h1);
   endtask

   task automatic t_div(input logic [6:0] d);
      logic [31:0] r;
      logic        e;
      int          n;
      int          f;
      f = 129 - d;
      apb(1'b1, clock_pkg::DIV_CTRL_OFFSET, {24'h0, 1'b1, d}, r, e);
      repeat (4) @(posedge pclk);
      apb(1'b0, clock_pkg::STATUS_OFFSET, 32'h0, r, e);
      check(r, {16'h0, 8'(f), 8'h17});
      n = 0;
      repeat (2 * f)
      begin
         @(posedge pclk);
         n += (sys_clk_en === 1'b1);
      end
      check(n, 2);
      // Select must not move while already enabled
      apb(1'b1, clock_pkg::DIV_CTRL_OFFSET, {24'h0, 1'b1, d ^ 7'h01}, r, e);
      apb(1'b0, clock_pkg::STATUS_OFFSET, 32'h0, r, e);
      check(r, {16'h0, 8'(f), 8'h17});
      apb(1'b1, clock_pkg::DIV_CTRL_OFFSET, {24'h0, 1'b0, d ^ 7'h02}, r, e);
      repeat (f + 4) @(posedge pclk);
      apb(1'b0, clock_pkg::DIV_CTRL_OFFSET, 32'h0, r, e);
      check(r, {25'h0, d});
      apb(1'b0, clock_pkg::STATUS_OFFSET, 32'h0, r, e);
      check(r, 32'h00000107);
   endtask

   task automatic t_wake(input logic [7:0] fuse, input int s, input logic [1:0] kind);
      logic [31:0] r;
      logic        e;
      int          n;
      apb(1'b1, clock_pkg::FUSE_OFFSET, {24'h0, fuse}, r, e);
      @(posedge pclk) sleep_enter <= 1'b1;
      @(posedge pclk) sleep_enter <= 1'b0;
      repeat (3) @(posedge pclk);
      check({31'h0, cpu_run}, 32'h0);
      @(posedge pclk) wake_event <= 1'b1;
      @(posedge pclk) wake_event <= 1'b0;
      wait_run(n);
      check({31'h0, n >= s && n <= s + 4}, 32'h1);
      check({30'h0, osc_kind}, {30'h0, kind});
      check({27'h0, internal_cap_enable, osc_full_swing, osc_range},
            {27'h0, ~fuse[6] && kind != 2'h0, ~fuse[6], fuse[3:1]});
   endtask

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial
   begin
      failures = 0;
      n_compared = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      sleep_enter = 1'b0;
      wake_event = 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_startup();
      t_div(7'h7f);
      t_div(7'h7e);
      t_div(7'h00);
      t_wake(8'h45, 18, 2'h2);
      t_wake(8'h78, 6, 2'h2);
      t_wake(8'h4a, 258, 2'h0);
      t_wake(8'h6e, 1024, 2'h0);
      t_wake(8'h5b, 40, 2'h0);
      t_wake(8'h0e, 258, 2'h0);
      t_wake(8'h69, 60, 2'h1);
      t_wake(8'h09, 1024, 2'h1);
      conclude();
   end

   // A hang counts as a failure
   initial
   begin
      #250000;
      failures++;
      conclude();
   end
endmodule // clock_source_startup_and_divider_test
